// ### hdl/sbit_timer.sv
// sixteen bit interval timer with period match and axi4-lite registers
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sbit_params.svh"
module sbit_timer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// external count clock or gate pin, and cpu power state
	input wire logic ext_count_input,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt level
	output logic timer_irq
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------

	// decode the count source; gate is only honoured on the internal clock
	function automatic sbit_pkg::sbit_src_e src_of(input sbit_pkg::sbit_ctrl_s c);
		if (c.clock_source_sel) begin
			src_of = c.ext_clock_sync ? sbit_pkg::SRC_EXT_SYNC : sbit_pkg::SRC_EXT_ASYNC;
		end else begin
			src_of = c.gate_accumulate_en ? sbit_pkg::SRC_GATED : sbit_pkg::SRC_INTERNAL;
		end
	endfunction : src_of

	// map an address to a known register
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `SBIT_OFS_CONTROL) || (a == `SBIT_OFS_COUNT) ||
			(a == `SBIT_OFS_PERIOD) || (a == `SBIT_OFS_STATUS) || (a == `SBIT_OFS_MASK);
	endfunction : mapped

	// merge byte lanes of a 16-bit register
	function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		lanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : lanes

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	sbit_pkg::sbit_ctrl_s ctrl_ff, nxt_ctrl; // timer_control fields
	logic [15:0] count_ff, nxt_count;        // running count
	logic [15:0] period_ff, nxt_period;      // period_register
	logic [1:0] status_ff, nxt_status;       // sticky events
	logic [1:0] mask_ff, nxt_mask;           // interrupt enables
	logic [7:0] presc_ff, nxt_presc;         // prescale counter
	logic pin_async_ff;                      // raw pin, previous cycle
	logic pin_s1_ff, pin_s2_ff, pin_s3_ff;   // two-flop synchroniser plus history
	logic irq_ff, nxt_irq;
	// bus channel state
	logic aw_held_ff, nxt_aw_held;
	logic [7:0] aw_addr_ff, nxt_aw_addr;
	logic w_held_ff, nxt_w_held;
	logic [31:0] w_data_ff, nxt_w_data;
	logic [3:0] w_strb_ff, nxt_w_strb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;

	// combinational terms
	sbit_pkg::sbit_src_e src;
	logic [15:0] ctrl_word;  // control as software reads it
	logic [7:0] presc_tc;    // terminal count for the chosen ratio
	logic running;           // module allowed to count this cycle
	logic event_in;          // one count-clock event
	logic tick;              // prescaled tick
	logic gate_fall;         // falling edge of the gate pin
	logic do_write;          // address and data both held
	logic rd_take;           // read address taken
	logic rd_status;         // that read targets the status register

	// ------------------------------------------------------------------
	// pin capture
	// ------------------------------------------------------------------

	// the async path looks at the raw pin; the sync path only at stage two on,
	// so stage one stays private to the synchroniser
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pin_async_ff <= 1'b0;
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
			pin_s3_ff <= 1'b0;
		end else begin
			pin_async_ff <= ext_count_input;
			pin_s1_ff <= ext_count_input;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end

	// ------------------------------------------------------------------
	// count engine
	// ------------------------------------------------------------------

	// decode source, prescale ratio and whether the module may run
	always_comb begin
		src = src_of(ctrl_ff);
		ctrl_word = 16'h0000;
		ctrl_word[`SBIT_BIT_RUN] = ctrl_ff.run;
		ctrl_word[`SBIT_BIT_SIDL] = ctrl_ff.stop_in_idle;
		ctrl_word[`SBIT_BIT_GATE] = ctrl_ff.gate_accumulate_en;
		ctrl_word[`SBIT_BIT_PS_HI:`SBIT_BIT_PS_LO] = ctrl_ff.prescale_select;
		ctrl_word[`SBIT_BIT_SYNC] = ctrl_ff.ext_clock_sync;
		ctrl_word[`SBIT_BIT_CS] = ctrl_ff.clock_source_sel;
		case (ctrl_ff.prescale_select)
			2'h0: presc_tc = `SBIT_PS_TC_1;
			2'h1: presc_tc = `SBIT_PS_TC_8;
			2'h2: presc_tc = `SBIT_PS_TC_64;
			default: presc_tc = `SBIT_PS_TC_256;
		endcase
		// in sleep the internal clock is gone; only the async counter survives
		running = ctrl_ff.run
			&& !(cpu_idle && ctrl_ff.stop_in_idle)
			&& !(cpu_sleep && src != sbit_pkg::SRC_EXT_ASYNC);
		case (src)
			sbit_pkg::SRC_INTERNAL: event_in = 1'b1;
			sbit_pkg::SRC_GATED: event_in = pin_s2_ff;
			sbit_pkg::SRC_EXT_SYNC: event_in = pin_s2_ff && !pin_s3_ff;
			sbit_pkg::SRC_EXT_ASYNC: event_in = ext_count_input && !pin_async_ff;
			default: event_in = 1'b0;
		endcase
		gate_fall = running && (src == sbit_pkg::SRC_GATED) && !pin_s2_ff && pin_s3_ff;
		tick = running && event_in && (presc_ff == presc_tc);
	end

	// next prescale and count; a stopped timer holds its count
	always_comb begin
		nxt_presc = presc_ff;
		nxt_count = count_ff;
		if (!running) begin
			nxt_presc = 8'h00;
		end else if (event_in) begin
			nxt_presc = tick ? 8'h00 : presc_ff + 8'h01;
		end
		if (tick) begin
			// clear on the tick after the count already equals the period
			nxt_count = (count_ff == period_ff) ? 16'h0000 : count_ff + 16'h0001;
		end
		if (do_write && aw_addr_ff == `SBIT_OFS_COUNT) begin
			nxt_count = lanes(count_ff, w_data_ff, w_strb_ff); // software load wins
		end
	end

	// registers the counter path
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			presc_ff <= 8'h00;
			count_ff <= 16'h0000;
		end else begin
			presc_ff <= nxt_presc;
			count_ff <= nxt_count;
		end
	end

	// ------------------------------------------------------------------
	// registers and interrupt
	// ------------------------------------------------------------------

	// software writes, sticky events and the interrupt level
	always_comb begin
		logic [15:0] w16;
		w16 = 16'h0000;
		nxt_ctrl = ctrl_ff;
		nxt_period = period_ff;
		nxt_mask = mask_ff;
		nxt_status = status_ff;
		if (do_write) begin
			case (aw_addr_ff)
				`SBIT_OFS_CONTROL: begin
					w16 = lanes(ctrl_word, w_data_ff, w_strb_ff) & `SBIT_CTRL_MASK;
					nxt_ctrl.run = w16[`SBIT_BIT_RUN];
					nxt_ctrl.stop_in_idle = w16[`SBIT_BIT_SIDL];
					nxt_ctrl.gate_accumulate_en = w16[`SBIT_BIT_GATE];
					nxt_ctrl.prescale_select = w16[`SBIT_BIT_PS_HI:`SBIT_BIT_PS_LO];
					nxt_ctrl.ext_clock_sync = w16[`SBIT_BIT_SYNC];
					nxt_ctrl.clock_source_sel = w16[`SBIT_BIT_CS];
				end
				`SBIT_OFS_PERIOD: nxt_period = lanes(period_ff, w_data_ff, w_strb_ff);
				`SBIT_OFS_MASK: begin
					if (w_strb_ff[0]) begin
						nxt_mask = w_data_ff[1:0];
					end
				end
				default: nxt_mask = mask_ff;
			endcase
		end
		// a read of status clears it, but an event in the same cycle survives
		if (rd_take && rd_status) begin
			nxt_status = 2'h0;
		end
		if (tick && count_ff == period_ff) begin
			nxt_status[`SBIT_ST_MATCH] = 1'b1;
		end
		if (gate_fall) begin
			nxt_status[`SBIT_ST_GATE] = 1'b1;
		end
		nxt_irq = |(nxt_status & nxt_mask);
	end

	// registers the software-visible state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_ff <= sbit_pkg::sbit_ctrl_s'(7'h00);
			period_ff <= `SBIT_PERIOD_RST;
			mask_ff <= 2'h0;
			status_ff <= 2'h0;
			irq_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			period_ff <= nxt_period;
			mask_ff <= nxt_mask;
			status_ff <= nxt_status;
			irq_ff <= nxt_irq;
		end
	end

	// ------------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------------

	// address and data are held apart and joined once both are in
	always_comb begin
		nxt_aw_held = aw_held_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_held = w_held_ff;
		nxt_w_data = w_data_ff;
		nxt_w_strb = w_strb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		do_write = aw_held_ff && w_held_ff && !bvalid_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_held = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_held = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = mapped(aw_addr_ff) ? `SBIT_RESP_OKAY : `SBIT_RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
	end

	// read data is captured when the address is taken
	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		rd_take = s_axi_arvalid && s_axi_arready;
		rd_status = (s_axi_araddr == `SBIT_OFS_STATUS);
		if (rd_take) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = mapped(s_axi_araddr) ? `SBIT_RESP_OKAY : `SBIT_RESP_SLVERR;
			case (s_axi_araddr)
				`SBIT_OFS_CONTROL: nxt_rdata = {16'h0000, ctrl_word};
				`SBIT_OFS_COUNT: nxt_rdata = {16'h0000, count_ff};
				`SBIT_OFS_PERIOD: nxt_rdata = {16'h0000, period_ff};
				`SBIT_OFS_STATUS: nxt_rdata = {30'h0, status_ff};
				`SBIT_OFS_MASK: nxt_rdata = {30'h0, mask_ff};
				default: nxt_rdata = 32'h00000000;
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	// registers the bus channels; readies are simple functions of held state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_held_ff <= 1'b0;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `SBIT_RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `SBIT_RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			aw_held_ff <= nxt_aw_held;
			aw_addr_ff <= nxt_aw_addr;
			w_held_ff <= nxt_w_held;
			w_data_ff <= nxt_w_data;
			w_strb_ff <= nxt_w_strb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			// one write in flight: each ready only while its own channel holds nothing and no response owed
			s_axi_awready <= !nxt_aw_held && !nxt_bvalid && !(nxt_w_held && aw_held_ff);
			s_axi_wready <= !nxt_w_held && !nxt_bvalid && !(nxt_aw_held && w_held_ff);
			s_axi_arready <= !nxt_rvalid && !rd_take;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign timer_irq = irq_ff;

endmodule : sbit_timer

// ### inc/sbit_params.svh
// offsets, field positions, reset values and ratios of the interval timer
`ifndef SBIT_PARAMS_SVH
`define SBIT_PARAMS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define SBIT_OFS_CONTROL 8'h00
`define SBIT_OFS_COUNT 8'h04
`define SBIT_OFS_PERIOD 8'h08
`define SBIT_OFS_STATUS 8'h0C
`define SBIT_OFS_MASK 8'h10

// ------------------------------------------------------------------
// control field positions
// ------------------------------------------------------------------
`define SBIT_BIT_RUN 15
`define SBIT_BIT_SIDL 13
`define SBIT_BIT_GATE 6
`define SBIT_BIT_PS_HI 5
`define SBIT_BIT_PS_LO 4
`define SBIT_BIT_SYNC 2
`define SBIT_BIT_CS 1
`define SBIT_CTRL_MASK 16'hA076

// ------------------------------------------------------------------
// status bits, reset values, prescale terminal counts (ratio - 1)
// ------------------------------------------------------------------
`define SBIT_ST_MATCH 0
`define SBIT_ST_GATE 1
`define SBIT_CTRL_RST 16'h0000
`define SBIT_PERIOD_RST 16'hFFFF
`define SBIT_PS_TC_1 8'h00
`define SBIT_PS_TC_8 8'h07
`define SBIT_PS_TC_64 8'h3F
`define SBIT_PS_TC_256 8'hFF
`define SBIT_RESP_OKAY 2'h0
`define SBIT_RESP_SLVERR 2'h2

`endif

// ### inc/sbit_pkg.sv
// types shared by the interval timer
package sbit_pkg;

	// ------------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------------
	typedef struct packed {
		logic run;            // timer_run_bit
		logic stop_in_idle;   // halt while cpu idles
		logic gate_accumulate_en;
		logic [1:0] prescale_select;
		logic ext_clock_sync;
		logic clock_source_sel;
	} sbit_ctrl_s;

	// count source as decoded from the control fields
	typedef enum logic [1:0] {
		SRC_INTERNAL,
		SRC_GATED,
		SRC_EXT_SYNC,
		SRC_EXT_ASYNC
	} sbit_src_e;

endpackage : sbit_pkg

// ### verif/sbit_pin_model.sv
// model of the external count clock and gate pin
`timescale 1ns/1ps
module sbit_pin_model (
	// clock
	input wire logic clk_sys,
	// settings from the bench
	input wire logic toggle_en,
	input wire logic [7:0] half_cycles,
	input wire logic idle_level,
	// pin toward the timer
	output logic ext_count_input
);
	logic [7:0] cnt_ff; // cycles spent in the present half period
	logic [7:0] nxt_cnt;
	logic pin_ff; // pin level
	logic nxt_pin;
	// free clock while enabled, else a steady gate level
	always_comb begin
		nxt_cnt = cnt_ff + 8'h01;
		nxt_pin = pin_ff;
		if (!toggle_en) begin
			nxt_cnt = 8'h00;
			nxt_pin = idle_level; // gate level in gated mode
		end else if (cnt_ff >= half_cycles) begin
			nxt_cnt = 8'h00;
			nxt_pin = !pin_ff; // rising edges are what is counted
		end
	end
	always_ff @(posedge clk_sys) begin
		cnt_ff <= nxt_cnt;
		pin_ff <= nxt_pin;
	end
	assign ext_count_input = pin_ff;
endmodule : sbit_pin_model

// ### verif/sbit_timer_checker.sv
// port checker of the interval timer, bound to its top module
`timescale 1ns/1ps
module sbit_timer_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// write channels
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt level
	input wire logic timer_irq
);
	// ------------------------------------------------------------------
	// one domain: shared clock and reset
	// ------------------------------------------------------------------
	default clocking dck @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [7:0] rd_addr_ff; // address of the read in flight
	logic [7:0] nxt_rd_addr;
	// capture the address so the answer can be judged per register
	always_comb begin
		nxt_rd_addr = rd_addr_ff;
		if (s_axi_arvalid && s_axi_arready) nxt_rd_addr = s_axi_araddr;
	end
	always_ff @(posedge clk_sys) rd_addr_ff <= nxt_rd_addr;
	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	rst_quiet_a: assert property (
		$fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid && !timer_irq) else $error("busy after reset");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid) else $error("write response late");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read data late");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("second write taken");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	err_zero_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	ctrl_rsvd_a: assert property (
		s_axi_rvalid && rd_addr_ff == 8'h00 |-> (s_axi_rdata & 32'hFFFF5F89) == 32'h0)
		else $error("unused control bits set");
	// main scenarios reached
	cover property ($rose(timer_irq));
	cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule : sbit_timer_checker
bind sbit_timer sbit_timer_checker sbit_timer_checker_inst (.*);

// ### verif/sbit_timer_tb.sv
// self-checking bench of the interval timer
`timescale 1ns/1ps
`include "sbit_params.svh"
module sbit_timer_tb;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic clk_sys, reset, cpu_idle, cpu_sleep, ext_count_input, timer_irq;
	logic toggle_en, idle_level;
	logic [7:0] half_cycles, s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, prev;
	integer seed, n_fail, samples_checked, i, p;
	logic [31:0] rst_val [5] = '{32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0}; // by offset / 4
	sbit_timer sbit_timer_inst (.*);
	sbit_pin_model sbit_pin_model_inst (.*);
	// ------------------------------------------------------------------
	// expectations and checks
	// ------------------------------------------------------------------
	function automatic int ratio(input int ps);
		return (ps == 3) ? 256 : (1 << (3 * ps));
	endfunction : ratio
	function automatic int edges(input int h, input int n);
		return n / (2 * (h + 1));
	endfunction : edges
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// an unknown value falls to the low bound and so fails
	task rng(input logic [31:0] got, input int lo, input int hi);
		chk(got, ((got >= lo && got <= hi) === 1'h1) ? got : 32'(lo));
	endtask : rng
	// ------------------------------------------------------------------
	// bus master: hold each channel until its ready edge
	// ------------------------------------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int t;
		logic ok, ta, tw;
		logic [1:0] rsp;
		t = 0;
		rsp = 2'h3;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			#1;
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			ok = s_axi_bvalid && s_axi_bready;
			rsp = ok ? s_axi_bresp : 2'h3; // a wait that runs out reads as a bad code
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (t > 1 && !ok) s_axi_bready <= 1'h1; // late ready exercises the hold
			t++;
		end while (!ok && t < 60);
		s_axi_bready <= 1'h0;
		chk(32'(rsp), 32'(er));
	endtask : wr
	task rdr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
		int t;
		logic ok, ta;
		logic [1:0] rsp;
		t = 0;
		rsp = 2'h3;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			#1;
			ta = s_axi_arvalid && s_axi_arready;
			ok = s_axi_rvalid && s_axi_rready;
			rsp = ok ? s_axi_rresp : 2'h3;
			v = s_axi_rdata;
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'h0;
			if (t > 1 && !ok) s_axi_rready <= 1'h1;
			t++;
		end while (!ok && t < 60);
		s_axi_rready <= 1'h0;
		chk(32'(rsp), 32'(er));
	endtask : rdr
	// interrupt level looked at mid-cycle, within n cycles
	task irq_is(input logic e, input int n);
		@(negedge clk_sys);
		for (int k = 0; k < n && timer_irq !== e; k++) @(negedge clk_sys);
		chk(32'(timer_irq), 32'(e));
		@(posedge clk_sys);
	endtask : irq_is
	task print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	// ------------------------------------------------------------------
	// clock and watchdog (run needs some 16000 cycles)
	// ------------------------------------------------------------------
	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#6000000;
		n_fail++;
		print_verdict();
	end
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		seed = 36848;
		n_fail = 0;
		samples_checked = 0;
		{reset, cpu_idle, cpu_sleep, toggle_en, idle_level} = 5'h10;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, half_cycles} = 56'h0;
		s_axi_wstrb = 4'hF; // full words only
		repeat (20) @(posedge clk_sys);
		reset <= 1'h0;
		// reset values of every register
		for (i = 0; i < 5; i++) begin
			rdr(8'(4 * i), `SBIT_RESP_OKAY, rd);
			chk(rd, rst_val[i]);
		end
		// unused control bits, bits 14:0 all set first, then random
		for (i = 0; i < 3; i++) begin
			p = (i == 0) ? 32'h7FFF : ($random(seed) & 32'h7FFF);
			wr(`SBIT_OFS_CONTROL, 32'(p), `SBIT_RESP_OKAY);
			rdr(`SBIT_OFS_CONTROL, `SBIT_RESP_OKAY, rd);
			chk(rd, 32'(p) & 32'hA076);
		end
		// unmapped place refused both ways
		wr(8'h14, 32'h1234, `SBIT_RESP_SLVERR);
		rdr(8'h14, `SBIT_RESP_SLVERR, rd);
		chk(rd, 32'h0);
		// every prescale ratio, then the count holds while stopped
		for (i = 0; i < 4; i++) begin
			wr(`SBIT_OFS_COUNT, 32'h0, `SBIT_RESP_OKAY);
			wr(`SBIT_OFS_CONTROL, 32'h8000 | (32'(i) << 4), `SBIT_RESP_OKAY);
			repeat (40 * ratio(i)) @(posedge clk_sys);
			wr(`SBIT_OFS_CONTROL, 32'(i) << 4, `SBIT_RESP_OKAY);
			rdr(`SBIT_OFS_COUNT, `SBIT_RESP_OKAY, prev);
			rng(prev, 39, 45);
			repeat (300) @(posedge clk_sys);
			rdr(`SBIT_OFS_COUNT, `SBIT_RESP_OKAY, rd);
			chk(rd, prev);
		end
		// idle with stop set, idle without it, sleep on internal clock
		for (i = 0; i < 3; i++) begin
			cpu_idle <= (i < 2);
			cpu_sleep <= (i == 2);
			wr(`SBIT_OFS_COUNT, 32'h0, `SBIT_RESP_OKAY);
			wr(`SBIT_OFS_CONTROL, (i == 0) ? 32'hA000 : 32'h8000, `SBIT_RESP_OKAY);
			repeat (100) @(posedge clk_sys);
			wr(`SBIT_OFS_CONTROL, 32'h0, `SBIT_RESP_OKAY);
			rdr(`SBIT_OFS_COUNT, `SBIT_RESP_OKAY, rd);
			rng(rd, (i == 1) ? 100 : 0, (i == 1) ? 106 : 0);
		end
		cpu_idle <= 1'h0;
		cpu_sleep <= 1'h0;
		// external rising edges, async then sync; gate bit set but ignored
		for (i = 0; i < 2; i++) begin
			p = 2 + ($unsigned($random(seed)) % 6);
			half_cycles <= 8'(p);
			toggle_en <= 1'h1;
			cpu_sleep <= (i == 0); // the async counter keeps running in sleep
			wr(`SBIT_OFS_COUNT, 32'h0, `SBIT_RESP_OKAY);
			wr(`SBIT_OFS_CONTROL, 32'h8042 | (32'(i) << 2), `SBIT_RESP_OKAY);
			repeat (400) @(posedge clk_sys);
			wr(`SBIT_OFS_CONTROL, 32'h0, `SBIT_RESP_OKAY);
			toggle_en <= 1'h0;
			rdr(`SBIT_OFS_COUNT, `SBIT_RESP_OKAY, rd);
			rng(rd, edges(p, 400) - 2, edges(p, 400) + 2);
		end
		// gated accumulation, then the gate fall raises the interrupt
		wr(`SBIT_OFS_MASK, 32'h2, `SBIT_RESP_OKAY);
		idle_level <= 1'h1;
		wr(`SBIT_OFS_COUNT, 32'h0, `SBIT_RESP_OKAY);
		wr(`SBIT_OFS_CONTROL, 32'h8040, `SBIT_RESP_OKAY);
		repeat (60) @(posedge clk_sys);
		idle_level <= 1'h0;
		irq_is(1'h1, 8);
		repeat (20) @(posedge clk_sys);
		wr(`SBIT_OFS_CONTROL, 32'h0, `SBIT_RESP_OKAY);
		rdr(`SBIT_OFS_COUNT, `SBIT_RESP_OKAY, rd);
		rng(rd, 58, 68);
		rdr(`SBIT_OFS_STATUS, `SBIT_RESP_OKAY, rd);
		chk(rd, 32'h2);
		// period match: masked first, then unmasked, then read-clear
		wr(`SBIT_OFS_MASK, 32'h0, `SBIT_RESP_OKAY);
		p = 2 + ($unsigned($random(seed)) % 8);
		wr(`SBIT_OFS_PERIOD, 32'(p), `SBIT_RESP_OKAY);
		wr(`SBIT_OFS_COUNT, 32'h0, `SBIT_RESP_OKAY);
		wr(`SBIT_OFS_CONTROL, 32'h8000, `SBIT_RESP_OKAY);
		repeat (30) @(posedge clk_sys);
		irq_is(1'h0, 1);
		wr(`SBIT_OFS_MASK, 32'h1, `SBIT_RESP_OKAY); // interrupt enabled last
		irq_is(1'h1, 5);
		wr(`SBIT_OFS_CONTROL, 32'h0, `SBIT_RESP_OKAY);
		rdr(`SBIT_OFS_COUNT, `SBIT_RESP_OKAY, rd);
		rng(rd, 0, p);
		rdr(`SBIT_OFS_STATUS, `SBIT_RESP_OKAY, rd);
		chk(rd, 32'h1);
		rdr(`SBIT_OFS_STATUS, `SBIT_RESP_OKAY, rd);
		chk(rd, 32'h0);
		irq_is(1'h0, 3);
		// mid-run reset brings every register back to its reset value
		wr(`SBIT_OFS_CONTROL, 32'h8046, `SBIT_RESP_OKAY);
		reset <= 1'h1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'h0;
		for (i = 0; i < 5; i++) begin
			rdr(8'(4 * i), `SBIT_RESP_OKAY, rd);
			chk(rd, rst_val[i]);
		end
		print_verdict();
	end
endmodule : sbit_timer_tb
